// ==== rtl/dio_counter.sv ====
// Purpose: 16-channel digital input card: state, edge counting, interrupts
// Assumes: commands are single-cycle strobes with a logical channel number
// Notes:   answers appear one cycle after the command (transfer words from two cycles), with rsp_valid_o
//
// Function
// - state bit is 1 for high input
// - logical 16-31 reads present state
// - logical number picks count or state
// - slot read packs all states, bit per channel
// - read-and-clear returns count then zeroes
// - preset loads counter with supplied number
// - per-channel direction chooses detected edges
// - event function is channel plus sixteen
// - arm command enables counter or event interrupt
// - disarm command disables chosen interrupt type
// - slot reset restores power-on state
// - identity query returns card code
// - transfer delivers one reading per cycle, default one
// - signed 32-bit up-counter per channel
// - counting idle after reset
// - one direction shared by event and counter
// - pending kept, lowest channel first, counter first
`timescale 1ns/1ps

module dio_counter
    import dio_counter_pkg::*;
(
    input  wire logic              sys_clk_i,     // system clock
    input  wire logic              reset_i,       // async reset, active high
    input  wire logic [NUM_CH-1:0] din_i,         // channel input pins
    input  wire logic              cmd_valid_i,   // command strobe
    input  wire logic [3:0]        cmd_i,         // command code
    input  wire logic [LCH_W-1:0]  lch_i,         // logical channel number
    input  wire logic [CNT_W-1:0]  cmd_data_i,    // preset value or direction
    input  wire logic [7:0]        xfer_count_i,  // transfer count, 0 means 1
    output logic                   cmd_ready_o,   // command may be issued
    output logic                   rsp_valid_o,   // answer strobe
    output logic [CNT_W-1:0]       rsp_data_o,    // answer data
    output logic                   irq_o,         // interrupt pending
    output logic [3:0]             irq_ch_o,      // channel presented
    output logic                   irq_is_event_o // 1 event, 0 counter
);

    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] sync1_q;   // first stage, read only by sync2
    logic [NUM_CH-1:0] sync2_q;   // present state
    logic [NUM_CH-1:0] prev_q;    // previous sample
    logic [NUM_CH-1:0] edge_hit;  // programmed edge this cycle

    // two flops then compare with last sample
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= din_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // ------------------------------------------------------------
    // per-channel state
    // ------------------------------------------------------------
    dir_t              dir_q   [NUM_CH];   // shared direction
    logic [CNT_W-1:0]  cnt_q   [NUM_CH];   // signed up-counters
    logic [NUM_CH-1:0] cen_q;              // counter interrupt armed
    logic [NUM_CH-1:0] een_q;              // event interrupt armed
    logic [NUM_CH-1:0] cpend_q;            // counter interrupt pending
    logic [NUM_CH-1:0] epend_q;            // event interrupt pending

    // decode of the command
    wire        is_event   = lch_i[4];
    wire [3:0]  ch         = lch_i[3:0];                     // physical channel
    wire        do_cmd     = cmd_valid_i && cmd_ready_o;
    wire        do_preset  = do_cmd && (cmd_i == counter_preset_cmd) && !is_event;
    wire        do_clear   = do_cmd && (cmd_i == read_and_clear_cmd) && !is_event;
    wire        do_edge    = do_cmd && (cmd_i == edge_set_cmd);
    wire        do_arm     = do_cmd && (cmd_i == interrupt_arm_cmd);
    wire        do_disarm  = do_cmd && (cmd_i == interrupt_disarm_cmd);
    wire        do_ack     = do_cmd && (cmd_i == interrupt_ack_cmd);
    wire        do_rst     = do_cmd && (cmd_i == slot_reset_cmd);

    // detected edge by direction; idle detects nothing
    function automatic logic edge_of(input dir_t d, input logic now, input logic was);
        edge_of = ((d == rising_direction_code) && now && !was) ||
                  ((d == falling_direction_code) && !now && was);
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            edge_hit[i] = edge_of(dir_q[i], sync2_q[i], prev_q[i]);
        end
    end

    // interrupt presentation: lowest channel, counter first
    logic [3:0] pick_ch;
    logic       pick_ev;
    logic       pick_any;
    always_comb begin
        pick_ch  = 4'h0;
        pick_ev  = 1'b0;
        pick_any = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (cpend_q[i] || epend_q[i]) begin
                pick_ch  = 4'(i);
                pick_ev  = !cpend_q[i];
                pick_any = 1'b1;
            end
        end
    end

    // counters, directions and interrupt state
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                dir_q[i] <= IDLE_DIRECTION_CODE;
                cnt_q[i] <= CNT_RST;
            end
            cen_q   <= '0;
            een_q   <= '0;
            cpend_q <= '0;
            epend_q <= '0;
        end else if (do_rst) begin
            // slot reset, same as power-on
            for (int i = 0; i < NUM_CH; i++) begin
                dir_q[i] <= IDLE_DIRECTION_CODE;
                cnt_q[i] <= CNT_RST;
            end
            cen_q   <= '0;
            een_q   <= '0;
            cpend_q <= '0;
            epend_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // preset or clear win over a same-cycle count
                if (do_preset && ch == 4'(i)) begin
                    cnt_q[i] <= cmd_data_i;
                end else if (do_clear && ch == 4'(i)) begin
                    cnt_q[i] <= CNT_RST;
                end else if (edge_hit[i]) begin
                    cnt_q[i] <= cnt_q[i] + 32'h0000_0001;        // wraps
                end
                if (do_edge && ch == 4'(i)) begin
                    dir_q[i] <= dir_t'(cmd_data_i[1:0]);
                end
                // pending: set wins over service
                if (edge_hit[i] && cen_q[i]) begin
                    cpend_q[i] <= 1'b1;
                end else if (do_ack && pick_any && !pick_ev && pick_ch == 4'(i)) begin
                    cpend_q[i] <= 1'b0;
                end
                if (edge_hit[i] && een_q[i]) begin
                    epend_q[i] <= 1'b1;
                end else if (do_ack && pick_any && pick_ev && pick_ch == 4'(i)) begin
                    epend_q[i] <= 1'b0;
                end
                // arm, disarm, auto-disarm when serviced
                if (do_arm && ch == 4'(i) && !is_event) begin
                    cen_q[i] <= 1'b1;
                end else if ((do_disarm && ch == 4'(i) && !is_event) ||
                             (do_ack && pick_any && !pick_ev && pick_ch == 4'(i))) begin
                    cen_q[i] <= 1'b0;
                end
                if (do_arm && ch == 4'(i) && is_event) begin
                    een_q[i] <= 1'b1;
                end else if ((do_disarm && ch == 4'(i) && is_event) ||
                             (do_ack && pick_any && pick_ev && pick_ch == 4'(i))) begin
                    een_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // answers
    // ------------------------------------------------------------
    logic [7:0]       xfer_left_q;   // readings still to transfer
    logic [3:0]       xfer_ch_q;
    logic             xfer_ev_q;

    assign cmd_ready_o = (xfer_left_q == 8'h00);

    wire [CNT_W-1:0] state_word = {{(CNT_W-NUM_CH){1'b0}}, sync2_q};
    wire [CNT_W-1:0] chan_word  = is_event ? {31'h0, sync2_q[ch]}
                                           : cnt_q[ch];
    wire [CNT_W-1:0] xfer_word  = xfer_ev_q ? {31'h0, sync2_q[xfer_ch_q]} : cnt_q[xfer_ch_q];
    wire             do_xfer    = do_cmd && (cmd_i == reading_transfer_cmd);

    // one answer per cycle; transfer holds off new commands
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= CNT_RST;
            xfer_left_q <= 8'h00;
            xfer_ch_q   <= 4'h0;
            xfer_ev_q   <= 1'b0;
        end else if (xfer_left_q != 8'h00) begin
            // a reading is always available here, so deliver one per cycle
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= xfer_word;
            xfer_left_q <= xfer_left_q - 8'h01;
        end else begin
            rsp_valid_o <= 1'b0;
            if (do_xfer) begin
                xfer_left_q <= (xfer_count_i == 8'h00) ? 8'h01 : xfer_count_i;
                xfer_ch_q   <= ch;
                xfer_ev_q   <= is_event;
            end else if (do_cmd) begin
                case (cmd_i)
                    single_channel_read_cmd: begin
                        rsp_valid_o <= 1'b1;
                        rsp_data_o  <= chan_word;
                    end
                    read_and_clear_cmd: begin
                        rsp_valid_o <= 1'b1;
                        rsp_data_o  <= cnt_q[ch];                         // old value
                    end
                    slot_read_cmd: begin
                        rsp_valid_o <= 1'b1;
                        rsp_data_o  <= state_word;
                    end
                    identity_query_cmd: begin
                        rsp_valid_o <= 1'b1;
                        rsp_data_o  <= {24'h0, CARD_ID};
                    end
                    default: begin
                        rsp_valid_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign irq_o          = pick_any;
    assign irq_ch_o       = pick_ch;
    assign irq_is_event_o = pick_ev;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_clear_zero;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_clear && !do_rst |=> cnt_q[$past(ch)] == CNT_RST;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("counter not zeroed");

    property p_preset;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_preset |=> cnt_q[$past(ch)] == $past(cmd_data_i);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");

    property p_id;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_cmd && cmd_i == identity_query_cmd |=> rsp_valid_o && rsp_data_o[7:0] == CARD_ID;
    endproperty
    a_id: assert property (p_id) else $error("bad identity answer");

    property p_slot_read;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_cmd && cmd_i == slot_read_cmd |=> rsp_data_o[NUM_CH-1:0] == $past(sync2_q);
    endproperty
    a_slot_read: assert property (p_slot_read) else $error("slot read mismatch");

    property p_state_read;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_cmd && cmd_i == single_channel_read_cmd && is_event |=> rsp_data_o[CNT_W-1:1] == '0;
    endproperty
    a_state_read: assert property (p_state_read) else $error("state read not one bit");

    property p_xfer_default;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_xfer && xfer_count_i == 8'h00 |=> xfer_left_q == 8'h01 ##1 rsp_valid_o && xfer_left_q == 8'h00;
    endproperty
    a_xfer_default: assert property (p_xfer_default) else $error("default transfer not one");

    property p_arm_event;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_arm && is_event && !do_rst |=> een_q[$past(ch)];
    endproperty
    a_arm_event: assert property (p_arm_event) else $error("event not armed");

    property p_rst_clean;
        @(posedge sys_clk_i) disable iff (reset_i)
        do_rst |=> !irq_o && cen_q == '0 && een_q == '0;
    endproperty
    a_rst_clean: assert property (p_rst_clean) else $error("slot reset incomplete");

    property p_counter_first;
        @(posedge sys_clk_i) disable iff (reset_i)
        irq_o |-> !(irq_is_event_o && cpend_q[irq_ch_o]) &&
                  ((cpend_q | epend_q) & ((16'h0001 << irq_ch_o) - 16'h0001)) == 16'h0000;
    endproperty
    a_counter_first: assert property (p_counter_first) else $error("interrupt presented out of order");

endmodule // dio_counter

// ==== rtl/dio_counter_pkg.sv ====
// Purpose: shared constants for the digital input event counter card
// Assumes: one system clock, commands arrive as single-cycle strobes
// Notes:   logical channel number selects both channel and function
package dio_counter_pkg;

    // ------------------------------------------------------------
    // card geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH      = 16;            // physical channels
    localparam int unsigned LCH_W       = 5;             // logical channel number width
    localparam int unsigned CNT_W       = 32;            // counter width
    localparam logic [4:0]  EVENT_BASE  = 5'h10;         // event/state range starts here

    // ------------------------------------------------------------
    // card type code, value is arbitrary
    // ------------------------------------------------------------
    localparam logic [7:0]  CARD_ID     = 8'h5A;

    // ------------------------------------------------------------
    // command encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE                   = 4'h0,
        single_channel_read_cmd    = 4'h1,
        read_and_clear_cmd         = 4'h2,
        counter_preset_cmd         = 4'h3,
        interrupt_arm_cmd          = 4'h4,
        interrupt_disarm_cmd       = 4'h5,
        identity_query_cmd         = 4'h6,
        reading_transfer_cmd       = 4'h7,
        slot_read_cmd              = 4'h8,
        edge_set_cmd               = 4'h9,
        slot_reset_cmd             = 4'hA,
        interrupt_ack_cmd          = 4'hB
    } cmd_t;

    // edge direction codes
    typedef enum logic [1:0] {
        IDLE_DIRECTION_CODE        = 2'h0,
        rising_direction_code      = 2'h1,
        falling_direction_code     = 2'h2
    } dir_t;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

endpackage

// ==== sim/digital_input_event_counter_tb.sv ====
// Purpose: self-checking bench for the digital input event counter
// Assumes: inputs change at the falling edge, four cycles settle an input
// Notes:   transfer words start one edge after the take, one per cycle
`timescale 1ns/1ps

module digital_input_event_counter_tb
    import dio_counter_pkg::*;
;
    logic              sys_clk_i, reset_i, cmd_valid, ready, rsp_valid, irq, irq_ev;
    logic [NUM_CH-1:0] din;
    logic [3:0]        cmd, irq_ch;
    logic [LCH_W-1:0]  lch;
    logic [CNT_W-1:0]  cmd_data, rsp_data;
    logic [7:0]        xcount;
    int                err_count, num_checks;

    dio_counter u_dio_counter (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .din_i(din),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .lch_i(lch), .cmd_data_i(cmd_data),
        .xfer_count_i(xcount), .cmd_ready_o(ready), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .irq_o(irq), .irq_ch_o(irq_ch), .irq_is_event_o(irq_ev));
    host_model u_host_model (.sys_clk_i(sys_clk_i), .cmd_ready_i(ready), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .lch_o(lch),
        .cmd_data_o(cmd_data), .xfer_count_o(xcount));

    initial sys_clk_i = 1'b0;
    always #5 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input cmd_t c, input logic [4:0] l, input logic [31:0] d);
        logic v;
        logic [31:0] r;
        u_host_model.issue(c, 1'b1, l, d, 8'h00, v, r);
    endtask
    task automatic rd(input cmd_t c, input logic [4:0] l, input logic [31:0] exp);
        logic v;
        logic [31:0] r;
        u_host_model.issue(c, 1'b1, l, 32'h0000_0000, 8'h00, v, r);
        chk({31'h0, v}, 32'h0000_0001);
        chk(r, exp);
    endtask
    // set inputs then give the synchroniser time to settle
    task automatic drive(input logic [15:0] v);
        @(negedge sys_clk_i);
        din = v;
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic pulse(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            drive(16'h0001 << ch);
            drive(16'h0000);
        end
    endtask

    task automatic t_reset;
        chk({29'h0, irq, ready, rsp_valid}, 32'h0000_0002);
        rd(identity_query_cmd, 5'h00, {24'h0, CARD_ID});
        pulse(0, 2);
        rd(single_channel_read_cmd, 5'h00, 32'h0000_0000);
    endtask
    task automatic t_state;
        drive(16'hA5C3);
        for (int c = 0; c < 16; c++) begin
            rd(single_channel_read_cmd, 5'h10 + c[4:0], {31'h0, din[c]});
        end
        rd(slot_read_cmd, 5'h00, 32'h0000_A5C3);
        drive(16'h0000);
    endtask
    task automatic t_count;
        wr(edge_set_cmd, 5'h03, {30'h0, rising_direction_code});
        pulse(3, 3);
        rd(single_channel_read_cmd, 5'h03, 32'h0000_0003);
        wr(edge_set_cmd, 5'h1E, {30'h0, falling_direction_code});
        pulse(14, 2);
        rd(single_channel_read_cmd, 5'h0E, 32'h0000_0002);
    endtask
    task automatic t_preset;
        wr(counter_preset_cmd, 5'h03, 32'h7FFF_FFFF);
        pulse(3, 1);
        rd(read_and_clear_cmd, 5'h03, 32'h8000_0000);
        rd(single_channel_read_cmd, 5'h03, 32'h0000_0000);
    endtask
    task automatic t_irq;
        wr(edge_set_cmd, 5'h02, {30'h0, rising_direction_code});
        wr(interrupt_arm_cmd, 5'h12, 32'h0000_0000);
        wr(interrupt_arm_cmd, 5'h1E, 32'h0000_0000);
        drive(16'h4004);
        drive(16'h0000);
        chk({26'h0, irq, irq_ev, irq_ch}, 32'h0000_0032);
        wr(interrupt_ack_cmd, 5'h00, 32'h0000_0000);
        chk({26'h0, irq, irq_ev, irq_ch}, 32'h0000_003E);
        wr(interrupt_ack_cmd, 5'h00, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        pulse(14, 1);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(interrupt_arm_cmd, 5'h12, 32'h0000_0000);
        wr(interrupt_disarm_cmd, 5'h12, 32'h0000_0000);
        pulse(2, 1);
        chk({31'h0, irq}, 32'h0000_0000);
        // counter and event interrupt on one channel: counter goes first
        wr(edge_set_cmd, 5'h05, {30'h0, rising_direction_code});
        wr(interrupt_arm_cmd, 5'h05, 32'h0000_0000);
        wr(interrupt_arm_cmd, 5'h15, 32'h0000_0000);
        drive(16'h0020);
        chk({26'h0, irq, irq_ev, irq_ch}, 32'h0000_0025);
        wr(interrupt_ack_cmd, 5'h00, 32'h0000_0000);
        chk({26'h0, irq, irq_ev, irq_ch}, 32'h0000_0035);
        wr(interrupt_ack_cmd, 5'h00, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(interrupt_arm_cmd, 5'h05, 32'h0000_0000);
        wr(interrupt_disarm_cmd, 5'h05, 32'h0000_0000);
        drive(16'h0000);
        pulse(5, 1);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask
    // count transfer words; the first one stands one edge after the take
    task automatic t_xfer(input logic [7:0] n, input int words);
        logic v;
        logic [31:0] r;
        logic [31:0] first;
        int got;
        got = 0;
        first = 32'hFFFF_FFFF;
        u_host_model.issue(reading_transfer_cmd, 1'b1, 5'h15, 32'h0000_0000, n, v, r);
        if (words > 1) chk({31'h0, ready}, 32'h0000_0000);
        repeat (6) begin
            @(negedge sys_clk_i);
            if (rsp_valid === 1'b1) begin
                if (got == 0) first = rsp_data;
                got++;
            end
        end
        chk(first, 32'h0000_0001);
        chk(got, words);
    endtask
    task automatic t_slot_reset;
        logic v;
        logic [31:0] r;
        u_host_model.use_ch(5'h03);
        u_host_model.issue(edge_set_cmd, 1'b0, 5'h00, 32'h0000_0001, 8'h00, v, r);
        pulse(3, 1);
        rd(single_channel_read_cmd, 5'h03, 32'h0000_0001);
        wr(slot_reset_cmd, 5'h00, 32'h0000_0000);
        rd(single_channel_read_cmd, 5'h03, 32'h0000_0000);
        pulse(3, 1);
        rd(single_channel_read_cmd, 5'h03, 32'h0000_0000);
    endtask

    task automatic test_done;
        err_count += u_host_model.stall_count;
        if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        err_count = 0;
        num_checks = 0;
        reset_i = 1'b1;
        din = 16'h0000;
        repeat (16) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        t_reset();
        t_state();
        t_count();
        t_preset();
        t_irq();
        drive(16'h0020);
        t_xfer(8'h00, 1);
        t_xfer(8'h03, 3);
        drive(16'h0000);
        t_slot_reset();
        test_done();
    end

    // watchdog: the run needs well under a tenth of this span
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // digital_input_event_counter_tb

// ==== sim/host_model.sv ====
// Purpose: host side that issues channel commands to the card
// Assumes: commands driven at the falling edge, one strobe per command
// Notes:   released command lines carry the inverse of their last value
`timescale 1ns/1ps

module host_model
    import dio_counter_pkg::*;
(
    input  wire logic             sys_clk_i,    // system clock
    input  wire logic             cmd_ready_i,  // card accepts commands
    input  wire logic             rsp_valid_i,  // answer strobe
    input  wire logic [CNT_W-1:0] rsp_data_i,   // answer data
    output logic                  cmd_valid_o,  // command strobe
    output logic [3:0]            cmd_o,        // command code
    output logic [LCH_W-1:0]      lch_o,        // logical channel
    output logic [CNT_W-1:0]      cmd_data_o,   // preset or direction
    output logic [7:0]            xfer_count_o  // transfer count
);
    logic [LCH_W-1:0] use_q;                    // default target channel
    int               stall_count;              // commands that never saw ready

    initial begin
        cmd_valid_o  = 1'b0;
        cmd_o        = 4'h0;
        lch_o        = 5'h00;
        cmd_data_o   = 32'h0000_0000;
        xfer_count_o = 8'h00;
        use_q        = 5'h00;
        stall_count  = 0;
    end

    // remember the channel for later commands without their own
    task automatic use_ch(input logic [LCH_W-1:0] l);
        use_q = l;
    endtask

    // one command; answer sampled at the falling edge after the take
    task automatic issue(input cmd_t c, input logic own, input logic [LCH_W-1:0] l,
                         input logic [CNT_W-1:0] d, input logic [7:0] n,
                         output logic v, output logic [CNT_W-1:0] r);
        int k;
        k = 0;
        @(negedge sys_clk_i);
        // wait up to 50 cycles for the card to stop delivering before the strobe
        while (cmd_ready_i !== 1'b1 && k < 50) begin
            @(negedge sys_clk_i);
            k++;
        end
        // a card that stays busy is a failure, not a silent pass
        if (cmd_ready_i !== 1'b1) stall_count++;
        cmd_valid_o  = 1'b1;
        cmd_o        = c;
        lch_o        = own ? l : use_q;
        cmd_data_o   = d;
        xfer_count_o = n;
        @(negedge sys_clk_i);
        v            = rsp_valid_i;
        r            = rsp_data_i;
        // released lines flip so stale values are never trusted
        cmd_valid_o  = 1'b0;
        cmd_o        = ~cmd_o;
        lch_o        = ~lch_o;
        cmd_data_o   = ~cmd_data_o;
        xfer_count_o = ~xfer_count_o;
    endtask
endmodule // host_model
